/* File: include/tconv_pkg.sv */
`default_nettype none
package tconv_pkg;
    localparam int          RESULT_W        = 10;
    localparam int          BYTE_W          = 8;
    localparam int          CHAN_W          = 3;
    localparam int          ROUTE_LSB       = 3;
    localparam int          CLK_MHZ         = 25;
    localparam int          T_CONV_ANALOG_US = 9;
    localparam int          T_CONV_TEMP_US  = 27;
    localparam int          CONV_ANALOG_CYC = T_CONV_ANALOG_US * CLK_MHZ;
    localparam int          CONV_TEMP_CYC   = T_CONV_TEMP_US * CLK_MHZ;
    localparam logic [2:0]  CHAN_TEMP       = 3'h0;
    localparam logic [2:0]  CHAN_EXT1       = 3'h1;
    localparam logic [2:0]  CHAN_BANDGAP    = 3'h7;
    localparam logic [7:0]  THRESH_RESET    = 8'h99;
    localparam int          LINK_DIV        = 4;
    localparam logic [3:0]  REG_CMD         = 4'h0;
    localparam logic [3:0]  REG_WDATA       = 4'h1;
    localparam logic [3:0]  REG_RDATA       = 4'h2;
    localparam logic [3:0]  REG_STATUS      = 4'h3;
    localparam logic [3:0]  REG_CLEAR       = 4'h4;
    localparam logic [3:0]  REG_ENABLE      = 4'h5;
    localparam logic [3:0]  REG_LINES       = 4'h6;
    localparam int          EV_WDONE        = 0;
    localparam int          EV_RDONE        = 1;
    localparam int          EV_CONVDONE     = 2;
    localparam int          EV_OVERTEMP     = 3;
    localparam int          EV_W            = 4;
    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_BUSY = 2'b01,
        CV_DOWN = 2'b11
    } conv_state_t;
endpackage : tconv_pkg
`default_nettype wire

/* File: include/tconv_if.sv */
`default_nettype none
interface tconv_if;
    logic conversion_trigger_n;
    logic busy;
    logic overtemp_flag_n;
    logic sclk;
    logic rd_wr;
    logic data_dev_o;
    logic data_dev_oe;
    logic data_host_o;
    logic data_host_oe;
    logic data;
    // open bus: whoever enables drives, otherwise pulled high
    assign data = data_dev_oe ? data_dev_o : (data_host_oe ? data_host_o : 1'b1);
    modport device (
        input  conversion_trigger_n, sclk, rd_wr, data,
        output busy, overtemp_flag_n, data_dev_o, data_dev_oe
    );
    modport host (
        input  busy, overtemp_flag_n, data,
        output conversion_trigger_n, sclk, rd_wr, data_host_o, data_host_oe
    );
endinterface : tconv_if
`default_nettype wire

/* File: rtl/tconv_device.sv */
`default_nettype none
// Function
// - trigger falling edge starts 10-bit conversion
// - hold on trigger edge, track at end
// - trigger low at end enters power-down
// - temperature result above threshold drives flag low
// - read start (rd_wr rise) releases flag
// - channel register selects converted input
// - one shared data pin both directions
// - shift out on sclk fall, in on rise
// - host sets rd_wr before each transfer
// - five zero MSBs load channel, else threshold
// - 000 temperature default, 001 ext1, 111 bandgap
// - busy 9 us analog, 27 us temperature
// - lower temperature result releases flag
module tconv_device #(
    parameter int CONV_TEMP_CYC   = tconv_pkg::CONV_TEMP_CYC,
    parameter int CONV_ANALOG_CYC = tconv_pkg::CONV_ANALOG_CYC
) (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    tconv_if.device                            link,
    input  wire logic [tconv_pkg::RESULT_W-1:0] sample_temp,
    input  wire logic [tconv_pkg::RESULT_W-1:0] sample_ext1,
    input  wire logic [tconv_pkg::RESULT_W-1:0] sample_bandgap,
    output logic                               track_hold,
    output logic                               power_down,
    output logic [tconv_pkg::CHAN_W-1:0]       channel,
    output logic [tconv_pkg::BYTE_W-1:0]       alarm_threshold
);
    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    logic [1:0] trig_s_q, sclk_s_q, rdwr_s_q, din_s_q;
    logic       trig_q, sclk_q, rdwr_q;
    always_ff @(posedge mclk) begin
        trig_s_q <= {trig_s_q[0], link.conversion_trigger_n};
        sclk_s_q <= {sclk_s_q[0], link.sclk};
        rdwr_s_q <= {rdwr_s_q[0], link.rd_wr};
        din_s_q  <= {din_s_q[0], link.data};
        trig_q   <= trig_s_q[1];
        sclk_q   <= sclk_s_q[1];
        rdwr_q   <= rdwr_s_q[1];
    end
    wire trig_fall = trig_q & ~trig_s_q[1];
    wire sclk_rise = ~sclk_q & sclk_s_q[1];
    wire sclk_fall = sclk_q & ~sclk_s_q[1];
    wire rdwr_rise = ~rdwr_q & rdwr_s_q[1];
    wire rdwr_fall = rdwr_q & ~rdwr_s_q[1];
    wire reading   = rdwr_s_q[1];
    // ----------------------------------------
    // conversion
    // ----------------------------------------
    tconv_pkg::conv_state_t st_q;
    logic [11:0]             cnt_q;
    logic [tconv_pkg::RESULT_W-1:0] result_q;
    logic                    conv_temp_q;
    logic [tconv_pkg::CHAN_W-1:0]   chan_q;
    logic [tconv_pkg::BYTE_W-1:0]   thresh_q;
    logic                    ot_n_q;
    wire [11:0] conv_len = (chan_q == tconv_pkg::CHAN_TEMP) ?
                           12'(CONV_TEMP_CYC) : 12'(CONV_ANALOG_CYC);
    wire [tconv_pkg::RESULT_W-1:0] chan_sample =
        (chan_q == tconv_pkg::CHAN_TEMP)    ? sample_temp :
        (chan_q == tconv_pkg::CHAN_BANDGAP) ? sample_bandgap :
        (chan_q == tconv_pkg::CHAN_EXT1)    ? sample_ext1 : '0;
    wire conv_end = (st_q == tconv_pkg::CV_BUSY) && (cnt_q == 12'h001);
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q        <= tconv_pkg::CV_IDLE;
            cnt_q       <= 12'h000;
            result_q    <= '0;
            conv_temp_q <= 1'b0;
        end else begin
            case (st_q)
                tconv_pkg::CV_IDLE, tconv_pkg::CV_DOWN: begin
                    if (trig_fall) begin
                        st_q        <= tconv_pkg::CV_BUSY;
                        cnt_q       <= conv_len;
                        result_q    <= chan_sample;
                        conv_temp_q <= (chan_q == tconv_pkg::CHAN_TEMP);
                    end
                end
                tconv_pkg::CV_BUSY: begin
                    // new edges ignored until done
                    cnt_q <= cnt_q - 12'h001;
                    if (conv_end) begin
                        st_q <= trig_s_q[1] ? tconv_pkg::CV_IDLE
                                            : tconv_pkg::CV_DOWN;
                    end
                end
                default: st_q <= tconv_pkg::CV_IDLE;
            endcase
        end
    end
    assign link.busy  = (st_q == tconv_pkg::CV_BUSY);
    assign track_hold = (st_q != tconv_pkg::CV_BUSY);
    assign power_down = (st_q == tconv_pkg::CV_DOWN);
    // ----------------------------------------
    // over-temperature flag
    // ----------------------------------------
    wire temp_done = conv_end && conv_temp_q;
    wire above     = result_q[9:2] > thresh_q;
    always_ff @(posedge mclk) begin
        if (rst) begin
            ot_n_q <= 1'b1;
        end else if (temp_done) begin
            ot_n_q <= ~above;
        end else if (rdwr_rise) begin
            ot_n_q <= 1'b1;
        end
    end
    assign link.overtemp_flag_n = ot_n_q;
    // ----------------------------------------
    // serial port
    // ----------------------------------------
    logic [tconv_pkg::BYTE_W-1:0]   sh_in_q;
    logic [3:0]                     nin_q;
    logic [tconv_pkg::RESULT_W-1:0] sh_out_q;
    logic                           dout_q;
    wire [tconv_pkg::BYTE_W-1:0] byte_nx = {sh_in_q[6:0], din_s_q[1]};
    wire byte_done = sclk_rise && !reading && (nin_q == 4'h7);
    wire to_chan   = (byte_nx[7:tconv_pkg::ROUTE_LSB] == 5'h00);
    always_ff @(posedge mclk) begin
        if (rst) begin
            sh_in_q  <= '0;
            nin_q    <= 4'h0;
            sh_out_q <= '0;
            dout_q   <= 1'b0;
            chan_q   <= tconv_pkg::CHAN_TEMP;
            thresh_q <= tconv_pkg::THRESH_RESET;
        end else begin
            if (rdwr_fall || rdwr_rise) begin
                nin_q <= 4'h0;
            end else if (sclk_rise && !reading) begin
                sh_in_q <= byte_nx;
                nin_q   <= byte_done ? 4'h0 : nin_q + 4'h1;
            end
            if (byte_done && to_chan) begin
                chan_q <= byte_nx[2:0];
            end
            if (byte_done && !to_chan) begin
                thresh_q <= byte_nx;
            end
            if (rdwr_rise || (reading && conv_end)) begin
                sh_out_q <= result_q; // held sample, not the live input
                dout_q   <= 1'b0;
            end else if (sclk_fall && reading) begin
                dout_q   <= sh_out_q[tconv_pkg::RESULT_W-1];
                sh_out_q <= {sh_out_q[8:0], 1'b0};
            end
        end
    end
    assign link.data_dev_o  = dout_q;
    assign link.data_dev_oe = reading;
    assign channel          = chan_q;
    assign alarm_threshold  = thresh_q;
endmodule : tconv_device
`default_nettype wire

/* File: rtl/tconv_host.sv */
`default_nettype none
module tconv_host (
    input  wire logic        mclk,
    input  wire logic        rst,
    tconv_if.host            link,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [15:0]      rdata,
    output logic             irq
);
    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    logic [1:0] busy_s_q, ot_s_q, din_s_q;
    logic       busy_q, ot_q;
    always_ff @(posedge mclk) begin
        busy_s_q <= {busy_s_q[0], link.busy};
        ot_s_q   <= {ot_s_q[0], link.overtemp_flag_n};
        din_s_q  <= {din_s_q[0], link.data};
        busy_q   <= busy_s_q[1];
        ot_q     <= ot_s_q[1];
    end
    // ----------------------------------------
    // command engine
    // ----------------------------------------
    // cmd bits: 0 write byte, 1 read result, 2 trigger pulse, 3 trigger level
    logic [7:0]  wbyte_q;
    logic [9:0]  rres_q;
    logic [4:0]  bits_q;
    logic [2:0]  div_q;
    logic        active_q, is_rd_q, sclk_q, rdwr_q, trig_q, trig_lvl_q;
    logic [3:0]  trig_cnt_q;
    logic [tconv_pkg::EV_W-1:0] stat_q, en_q;
    wire cmd_w   = wr && (addr == tconv_pkg::REG_CMD);
    wire go_wr   = cmd_w && wdata[0] && !active_q;
    wire go_rd   = cmd_w && wdata[1] && !active_q && !wdata[0];
    wire tick    = (div_q == 3'(tconv_pkg::LINK_DIV - 1));
    // frame closes half a period after the final rise, so the last bit still stands
    wire last    = tick && sclk_q && (bits_q == 5'h00);
    wire busy_fall = busy_q & ~busy_s_q[1];
    wire ot_fall   = ot_q & ~ot_s_q[1];
    always_ff @(posedge mclk) begin
        if (rst) begin
            wbyte_q    <= 8'h00;
            rres_q     <= '0;
            bits_q     <= 5'h00;
            div_q      <= 3'h0;
            active_q   <= 1'b0;
            is_rd_q    <= 1'b0;
            sclk_q     <= 1'b1;
            rdwr_q     <= 1'b0;
            trig_q     <= 1'b1;
            trig_lvl_q <= 1'b1;
            trig_cnt_q <= 4'h0;
        end else begin
            if (wr && addr == tconv_pkg::REG_WDATA) wbyte_q <= wdata[7:0];
            if (go_wr || go_rd) begin
                active_q <= 1'b1;
                is_rd_q  <= go_rd;
                rdwr_q   <= go_rd;
                bits_q   <= go_rd ? 5'h0a : 5'h08;
                div_q    <= 3'h0;
            end else if (active_q) begin
                div_q <= tick ? 3'h0 : div_q + 3'h1;
                if (tick) begin
                    sclk_q <= ~sclk_q;
                    // bit held from fall to fall so the device's rise sees it
                    if (sclk_q && !is_rd_q && bits_q != 5'h08) begin
                        wbyte_q <= {wbyte_q[6:0], 1'b0};
                    end
                    // read bit taken at the next fall: device and synchroniser lag
                    // exceed half a period, so the rise would be too early
                    if (sclk_q && is_rd_q && bits_q != 5'h0a) begin
                        rres_q <= {rres_q[8:0], din_s_q[1]};
                    end
                    if (!sclk_q) begin
                        bits_q <= bits_q - 5'h01;
                    end
                    if (last) begin
                        active_q <= 1'b0;
                        sclk_q   <= 1'b1;
                        rdwr_q   <= 1'b0; // fall closes the read; the rise released the flag
                    end
                end
            end
            if (cmd_w && wdata[2]) trig_cnt_q <= 4'hf;
            else if (trig_cnt_q != 4'h0) trig_cnt_q <= trig_cnt_q - 4'h1;
            if (cmd_w && wdata[2]) trig_lvl_q <= wdata[3];
            trig_q <= (trig_cnt_q != 4'h0) ? 1'b0 : trig_lvl_q;
        end
    end
    assign link.sclk                 = active_q ? sclk_q : 1'b1;
    assign link.rd_wr                = rdwr_q;
    assign link.conversion_trigger_n = trig_q;
    assign link.data_host_o          = wbyte_q[7];
    assign link.data_host_oe         = active_q && !is_rd_q;
    // ----------------------------------------
    // events and register read
    // ----------------------------------------
    wire [tconv_pkg::EV_W-1:0] ev = {ot_fall, busy_fall,
                                     last && is_rd_q, last && !is_rd_q};
    wire [tconv_pkg::EV_W-1:0] clr = (wr && addr == tconv_pkg::REG_CLEAR) ?
                                     wdata[tconv_pkg::EV_W-1:0] : '0;
    always_ff @(posedge mclk) begin
        if (rst) begin
            stat_q <= '0;
            en_q   <= '0;
            rdata  <= 16'h0000;
        end else begin
            stat_q <= (stat_q & ~clr) | ev; // set wins over clear
            if (wr && addr == tconv_pkg::REG_ENABLE) en_q <= wdata[tconv_pkg::EV_W-1:0];
            rdata <= 16'h0000;
            if (rd) begin
                case (addr)
                    tconv_pkg::REG_RDATA:  rdata <= {6'h00, rres_q};
                    tconv_pkg::REG_STATUS: rdata <= {12'h000, stat_q};
                    tconv_pkg::REG_ENABLE: rdata <= {12'h000, en_q};
                    tconv_pkg::REG_LINES:  rdata <= {13'h0000, active_q, ot_q, busy_q};
                    default:               rdata <= 16'h0000;
                endcase
            end
        end
    end
    assign irq = |(stat_q & en_q);
endmodule : tconv_host
`default_nettype wire

/* File: sim/tconv_props.sv */
`default_nettype none
module tconv_props #(
    parameter int CONV_TEMP_CYC   = tconv_pkg::CONV_TEMP_CYC,
    parameter int CONV_ANALOG_CYC = tconv_pkg::CONV_ANALOG_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic conversion_trigger_n,
    input wire logic busy,
    input wire logic overtemp_flag_n,
    input wire logic sclk,
    input wire logic rd_wr,
    input wire logic data_dev_o,
    input wire logic data_dev_oe,
    input wire logic data_host_o,
    input wire logic data_host_oe
);
    // ----------------------------------------
    // busy length counter and link properties
    // ----------------------------------------
    // busy comes straight from the device, so the count is exact; the window only adds a few cycles of slack
    logic [15:0] len_q;
    always_ff @(posedge mclk) begin
        len_q <= (rst || !busy) ? 16'h0000 : len_q + 16'h0001;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_trig_edge;
        $fell(conversion_trigger_n) && !busy;
    endsequence
    sequence s_conv_end;
        $fell(busy);
    endsequence
    a_trig_starts_busy: assert property (s_trig_edge |-> ##[1:5] busy)
        else $error("trigger edge did not start a conversion");
    a_busy_len_exact: assert property (s_conv_end |->
        (len_q >= CONV_ANALOG_CYC - 2 && len_q <= CONV_ANALOG_CYC + 3) ||
        (len_q >= CONV_TEMP_CYC - 2 && len_q <= CONV_TEMP_CYC + 3))
        else $error("busy length wrong");
    a_flag_after_conv: assert property ($fell(overtemp_flag_n) |-> !busy &&
        ($past(busy) || $past(busy, 2) || $past(busy, 3) || $past(busy, 4)))
        else $error("flag fell outside conversion end");
    a_flag_read_release: assert property ($rose(rd_wr) |-> ##[1:5] overtemp_flag_n)
        else $error("flag not released by read");
    a_oe_read_only: assert property (!rd_wr [*5] |-> !data_dev_oe)
        else $error("device drives data during write");
    a_dir_idle_clk: assert property ($changed(rd_wr) |-> sclk && $past(sclk))
        else $error("direction changed inside a frame");
    a_dev_out_stable: assert property ($rose(sclk) && data_dev_oe |->
        $stable(data_dev_o) ##1 $stable(data_dev_o))
        else $error("device data moved near sclk rise");
    a_host_out_stable: assert property ($rose(sclk) && data_host_oe |->
        $stable(data_host_o) ##1 $stable(data_host_o))
        else $error("host data moved near sclk rise");
endmodule : tconv_props
`default_nettype wire

/* File: sim/testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int T_CYC = 60;
    localparam int A_CYC = 30;
    logic mclk, rst, wr, rd, irq, track_hold, power_down;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, rv;
    logic [2:0]  channel;
    logic [7:0]  alarm_threshold;
    logic [9:0]  s_temp, s_ext1, s_bg;
    int          err_count, checks, cyc;
    tconv_if link ();
    tconv_device #(.CONV_TEMP_CYC(T_CYC), .CONV_ANALOG_CYC(A_CYC)) tconv_device_i (
        .mclk(mclk), .rst(rst), .link(link), .sample_temp(s_temp), .sample_ext1(s_ext1),
        .sample_bandgap(s_bg), .track_hold(track_hold), .power_down(power_down),
        .channel(channel), .alarm_threshold(alarm_threshold));
    tconv_host tconv_host_i (.mclk(mclk), .rst(rst), .link(link), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
    tconv_props #(.CONV_TEMP_CYC(T_CYC), .CONV_ANALOG_CYC(A_CYC)) tconv_props_i (
        .mclk(mclk), .rst(rst), .conversion_trigger_n(link.conversion_trigger_n),
        .busy(link.busy), .overtemp_flag_n(link.overtemp_flag_n), .sclk(link.sclk),
        .rd_wr(link.rd_wr), .data_dev_o(link.data_dev_o), .data_dev_oe(link.data_dev_oe),
        .data_host_o(link.data_host_o), .data_host_oe(link.data_host_oe));
    // ----------------------------------------
    // clock, timeout, bus and check tasks
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd
    // polls a sticky event bit under a bound, then clears it
    task automatic wait_ev(input int b);
        logic [15:0] v;
        for (int n = 0; n < 300; n++) begin
            reg_rd(tconv_pkg::REG_STATUS, v);
            if (v[b] === 1'b1) break;
        end
        check(16'(v[b]), 16'h0001);
        reg_wr(tconv_pkg::REG_CLEAR, 16'h0001 << b);
    endtask : wait_ev
    task automatic send_byte(input logic [7:0] b);
        reg_wr(tconv_pkg::REG_WDATA, {8'h00, b});
        reg_wr(tconv_pkg::REG_CMD, 16'h0001);
        wait_ev(tconv_pkg::EV_WDONE);
    endtask : send_byte
    task automatic conv(input logic lvl, input logic pd);
        reg_wr(tconv_pkg::REG_CMD, lvl ? 16'h000c : 16'h0004);
        for (int n = 0; n < 40 && link.busy !== 1'b1; n++) @(posedge mclk) #1;
        check(16'(link.busy), 16'h0001);
        check(16'(track_hold), 16'h0000);
        wait_ev(tconv_pkg::EV_CONVDONE);
        check(16'(track_hold), 16'h0001);
        check(16'(power_down), 16'(pd));
    endtask : conv
    task automatic rd_result(input logic [9:0] exp);
        reg_wr(tconv_pkg::REG_CMD, 16'h0002);
        wait_ev(tconv_pkg::EV_RDONE);
        reg_rd(tconv_pkg::REG_RDATA, rv);
        check(rv, {6'h00, exp});
        check(16'(link.overtemp_flag_n), 16'h0001);
    endtask : rd_result
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_route;
        logic [7:0] tab [4] = '{8'h01, 8'h07, 8'h08, 8'h00};
        logic [2:0] ch = tconv_pkg::CHAN_TEMP;
        logic [7:0] th = tconv_pkg::THRESH_RESET;
        foreach (tab[i]) begin
            send_byte(tab[i]);
            if (tab[i][7:3] == 5'h00) ch = tab[i][2:0];
            else th = tab[i];
            check(16'(channel), 16'(ch));
            check(16'(alarm_threshold), 16'(th));
        end
    endtask : s_route
    task automatic s_channels;
        send_byte(8'h01);
        conv(1'b1, 1'b0);
        rd_result(s_ext1);
        send_byte(8'h07);
        conv(1'b1, 1'b0);
        rd_result(s_bg);
        send_byte(8'h00);
    endtask : s_channels
    task automatic s_alarm;
        reg_wr(tconv_pkg::REG_ENABLE, 16'h0001 << tconv_pkg::EV_OVERTEMP);
        conv(1'b1, 1'b0);
        repeat (8) @(posedge mclk);
        check(16'(link.overtemp_flag_n), 16'h0000);
        check(16'(irq), 16'h0001);
        reg_wr(tconv_pkg::REG_CLEAR, 16'h0001 << tconv_pkg::EV_OVERTEMP);
        repeat (2) @(posedge mclk);
        check(16'(irq), 16'h0000);
        rd_result(s_temp);
        conv(1'b1, 1'b0);
        send_byte(8'hff);
        reg_wr(tconv_pkg::REG_ENABLE, 16'h0000);
        repeat (2) @(posedge mclk);
        check(16'(irq), 16'h0000);
        check(16'(link.overtemp_flag_n), 16'h0000);
        conv(1'b1, 1'b0);
        repeat (8) @(posedge mclk);
        check(16'(link.overtemp_flag_n), 16'h0001);
    endtask : s_alarm
    // a second edge mid-conversion must not restart the count
    task automatic s_retrig;
        reg_wr(tconv_pkg::REG_CMD, 16'h000c);
        repeat (25) @(posedge mclk);
        reg_wr(tconv_pkg::REG_CMD, 16'h000c);
        // a restarted count would still be running here
        repeat (T_CYC - 15) @(posedge mclk);
        check(16'(link.busy), 16'h0000);
        wait_ev(tconv_pkg::EV_CONVDONE);
        repeat (40) @(posedge mclk);
        check(16'(link.busy), 16'h0000);
    endtask : s_retrig
    initial begin
        rst = 1'b1;
        {wr, rd, addr, wdata} = '0;
        s_temp = 10'h2a0;
        s_ext1 = 10'h155;
        s_bg = 10'h200;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        check(16'(channel), 16'(tconv_pkg::CHAN_TEMP));
        check(16'(alarm_threshold), 16'(tconv_pkg::THRESH_RESET));
        check(16'(link.overtemp_flag_n), 16'h0001);
        s_route();
        s_channels();
        s_alarm();
        s_retrig();
        conv(1'b0, 1'b1);
        reg_rd(tconv_pkg::REG_LINES, rv);
        check(rv, 16'h0002);
        reg_rd(4'hf, rv);
        check(rv, 16'h0000);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
